// ===== wwdt_regs.vh
`ifndef WWDT_REGS_VH
`define WWDT_REGS_VH
// Register offsets (byte addresses)
`define WWDT_RESTART_COMMAND_OFS 8'h00
`define WWDT_CONFIGURATION_OFS 8'h04
`define WWDT_FAULT_FLAGS_OFS 8'h08
// Configuration reset value and field positions
`define WWDT_CFG_RESET 32'h3FFF2FFF
`define WWDT_CFG_RELOAD_LSB 0
`define WWDT_CFG_FIEN_BIT 12
`define WWDT_CFG_RSTEN_BIT 13
`define WWDT_CFG_PROC_BIT 14
`define WWDT_CFG_DIS_BIT 15
`define WWDT_CFG_WINDOW_LSB 16
`define WWDT_CFG_DBGHLT_BIT 28
`define WWDT_CFG_IDLEHLT_BIT 29
`define WWDT_CFG_USED_MASK 32'h3FFFFFFF
// Counter value after reset, the full twelve-bit count
`define WWDT_COUNT_RESET 12'hFFF
// Restart command fields
`define WWDT_KEY_LSB 24
`define WWDT_KEY_VALUE 8'hA5
`define WWDT_RESTART_BIT 0
// Status fields
`define WWDT_UNF_BIT 0
`define WWDT_ERR_BIT 1
// Prescaler ratio on the slow clock
`define WWDT_PRESCALE 8'h80
`endif

// ===== wwdt_prescaler.v
`timescale 1ns/100ps
// Divide-by-128 of the slow clock enable, restartable
module wwdt_prescaler (
   // Clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // Control
   input wire slow_en_i,
   input wire restart_i,
   input wire run_i,
   // Tick out
   output wire tick_o
);
`include "wwdt_regs.vh"
   reg [6:0] cnt_ff;
   reg [6:0] nxt_cnt;

   // Restart clears the phase so a full period follows every restart
   always @* begin
      nxt_cnt = cnt_ff;
      if (restart_i) begin
         nxt_cnt = 7'h00;
      end else if (run_i && slow_en_i) begin
         nxt_cnt = cnt_ff + 7'h01;
      end
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_ff <= 7'h00;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // Tick on the slow edge that wraps the count
   assign tick_o = run_i & slow_en_i & ~restart_i
      & ({1'b0, cnt_ff} == `WWDT_PRESCALE - 8'h01);
endmodule // wwdt_prescaler

// ===== wwdt_core.v
`timescale 1ns/100ps
// Operation
// R01: A 12-bit down counter loads from the reload count value field.
// R02: The counter decrements on slow clock ticks divided by 128.
// R03: After reset the reload value is 0xFFF with fault reset enabled.
// R04: A processor reset restarts the watchdog with its initial values.
// R05: The configuration takes only its first write until processor reset.
// R06: An accepted configuration write reloads the counter and restarts counting.
// R07: A keyed restart reloads the counter and restarts the prescaler at once.
// R08: A restart command write with a wrong key does nothing.
// R09: Software restarts only while the counter is within zero to window limit.
// R10: Underflow sets its flag and, if fault reset enabled, raises fault.
// R11: Restart above the window limit sets error and fault, even disabled.
// R12: A window limit at or above the reload value never errors.
// R13: Flags drive the interrupt only with fault interrupt enable set.
// R14: With fault reset enabled the fault requests a watchdog reset.
// R15: Status read or reset clears flags, interrupt and fault.
// R16: Counting halts in debug or idle when the matching halt bit is set.
// R17: The restart command key is 0xA5; any other key aborts the write.
// R18: Processor-only reset bit picks processor reset or all resets.
// R19: The timer disable bit stops the watchdog when set.
// R20: Underflow is a tick while the counter is zero; fault is a level.
module wwdt_core (
   // Clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // Register port
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output wire [31:0] rdata_o,
   // Slow clock enable, one cycle per slow clock period
   input wire slow_en_i,
   // System state pins
   input wire debug_state_i,
   input wire idle_state_i,
   // Fault signalling
   output wire irq_o,
   output wire fault_o,
   output wire reset_all_o,
   output wire reset_proc_o,
   // Counter observation
   output wire [11:0] count_o
);
`include "wwdt_regs.vh"
   reg [31:0] cfg_ff;
   reg cfg_locked_ff;
   reg [11:0] cnt_ff;
   reg unf_ff;
   reg err_ff;
   reg fault_ff;
   reg [31:0] rdata_ff;
   reg dbg_s1_ff;
   reg dbg_s2_ff;
   reg idle_s1_ff;
   reg idle_s2_ff;
   reg [11:0] nxt_cnt;
   reg nxt_unf;
   reg nxt_err;
   reg nxt_fault;
   reg [31:0] nxt_rdata;
   reg [31:0] nxt_cfg;
   reg irq_ff;
   reg reset_all_ff;
   reg reset_proc_ff;
   reg nxt_irq;
   reg nxt_reset_all;
   reg nxt_reset_proc;
   wire [11:0] reload_count_value;
   wire [11:0] restart_window_limit;
   wire fault_reset_enable;
   wire timer_disable;
   wire debug_halt;
   wire idle_halt;
   wire cfg_wr;
   wire cmd_wr;
   wire restart_request;
   wire status_rd;
   wire halted;
   wire run;
   wire tick;
   wire underflow;
   wire window_error;
   wire count_zero;
   wire reload_now;
   wire [11:0] load_value;
   wire set_unf;
   wire set_err;
   wire set_fault;
   wire clr_flags;
   wire rd_cfg;

   // Address match shared by read and write decode
   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // Twelve-bit field at a bit offset; reload and window share the layout
   function [11:0] field12;
      input [31:0] w;
      input integer lsb;
      begin
         field12 = w[lsb +: 12];
      end
   endfunction

   // Field views of the configuration register
   assign reload_count_value = field12(cfg_ff, `WWDT_CFG_RELOAD_LSB); // R01
   assign restart_window_limit = field12(cfg_ff, `WWDT_CFG_WINDOW_LSB);
   assign fault_reset_enable = cfg_ff[`WWDT_CFG_RSTEN_BIT];
   assign timer_disable = cfg_ff[`WWDT_CFG_DIS_BIT];
   assign debug_halt = cfg_ff[`WWDT_CFG_DBGHLT_BIT];
   assign idle_halt = cfg_ff[`WWDT_CFG_IDLEHLT_BIT];

   // Debug state comes from other logic; two flops before any use
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dbg_s1_ff <= 1'b0;
         dbg_s2_ff <= 1'b0;
      end else begin
         dbg_s1_ff <= debug_state_i;
         dbg_s2_ff <= dbg_s1_ff;
      end
   end

   // Idle state gets its own pair; only the second stage feeds logic
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         idle_s1_ff <= 1'b0;
         idle_s2_ff <= 1'b0;
      end else begin
         idle_s1_ff <= idle_state_i;
         idle_s2_ff <= idle_s1_ff;
      end
   end

   // Write decode; first write to configuration is the only one taken
   assign cfg_wr = wr_i & hit(addr_i, `WWDT_CONFIGURATION_OFS) & ~cfg_locked_ff; // R05
   assign cmd_wr = wr_i & hit(addr_i, `WWDT_RESTART_COMMAND_OFS)
      & (wdata_i[`WWDT_KEY_LSB +: 8] == `WWDT_KEY_VALUE); // R08 R17
   assign restart_request = cmd_wr & wdata_i[`WWDT_RESTART_BIT]; // R07
   assign status_rd = rd_i & hit(addr_i, `WWDT_FAULT_FLAGS_OFS);
   assign rd_cfg = rd_i & hit(addr_i, `WWDT_CONFIGURATION_OFS);

   // Halting stops the counter and freezes the prescaler phase
   assign halted = (debug_halt & dbg_s2_ff) | (idle_halt & idle_s2_ff); // R16
   assign run = ~timer_disable & ~halted; // R19

   // Prescaler is cleared by any reload so each period starts whole
   wwdt_prescaler u_presc (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .slow_en_i(slow_en_i),
      .restart_i(restart_request | cfg_wr), // R07
      .run_i(run),
      .tick_o(tick) // R02
   );

   // Window check ignores the disable bit on purpose
   assign count_zero = (cnt_ff == 12'h000);
   assign window_error = restart_request & (cnt_ff > restart_window_limit); // R11 R12
   assign underflow = tick & count_zero; // R20

   // A configuration write loads the value being written, not the old field
   assign reload_now = cfg_wr | (restart_request & ~window_error); // R06 R07
   assign load_value = cfg_wr ? field12(wdata_i, `WWDT_CFG_RELOAD_LSB) : reload_count_value;

   // Counter next value; it parks at zero so each later tick underflows again
   always @* begin
      nxt_cnt = cnt_ff;
      if (reload_now) begin
         nxt_cnt = load_value; // R06 R07
      end else if (tick && !count_zero) begin
         nxt_cnt = cnt_ff - 12'h001; // R02
      end
   end

   // Flag events; a set in the same cycle as a status read wins
   assign clr_flags = status_rd; // R15
   assign set_unf = underflow; // R10
   assign set_err = window_error; // R11
   assign set_fault = window_error | (underflow & fault_reset_enable); // R10 R11

   // Flag and fault next values
   always @* begin
      nxt_unf = unf_ff;
      nxt_err = err_ff;
      nxt_fault = fault_ff;
      if (clr_flags) begin
         nxt_unf = 1'b0;
         nxt_err = 1'b0;
         nxt_fault = 1'b0;
      end
      if (set_unf) begin
         nxt_unf = 1'b1;
      end
      if (set_err) begin
         nxt_err = 1'b1;
      end
      if (set_fault) begin
         nxt_fault = 1'b1; // R20
      end
   end

   // Next configuration, so registered outputs see a write in its own cycle
   always @* begin
      nxt_cfg = cfg_ff;
      if (cfg_wr) begin
         nxt_cfg = wdata_i & `WWDT_CFG_USED_MASK;
      end
   end

   // Configuration register
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_ff <= `WWDT_CFG_RESET; // R03 R04
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   // Lock flag; only a processor reset opens the configuration again
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_locked_ff <= 1'b0;
      end else if (cfg_wr) begin
         cfg_locked_ff <= 1'b1; // R05
      end
   end

   // Counter; any reset restarts it from the full count
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_ff <= `WWDT_COUNT_RESET; // R03 R04
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // Status flags and fault level; reset clears them
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         unf_ff <= 1'b0; // R14 R15
         err_ff <= 1'b0;
         fault_ff <= 1'b0;
      end else begin
         unf_ff <= nxt_unf;
         err_ff <= nxt_err;
         fault_ff <= nxt_fault;
      end
   end

   // Fault-side next values, from next state so they line up with the flags
   always @* begin
      nxt_irq = nxt_cfg[`WWDT_CFG_FIEN_BIT] & (nxt_unf | nxt_err); // R13
      nxt_reset_proc = nxt_fault & nxt_cfg[`WWDT_CFG_RSTEN_BIT]; // R14 R18
      nxt_reset_all = nxt_reset_proc & ~nxt_cfg[`WWDT_CFG_PROC_BIT]; // R18
   end

   // Registered so the reset controller never sees a decode glitch
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_ff <= 1'b0;
         reset_all_ff <= 1'b0;
         reset_proc_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
         reset_all_ff <= nxt_reset_all;
         reset_proc_ff <= nxt_reset_proc;
      end
   end

   // Read mux; only a strobed cycle loads data, so it stands one cycle
   always @* begin
      nxt_rdata = 32'h00000000;
      if (rd_cfg) begin
         nxt_rdata = cfg_ff;
      end else if (status_rd) begin
         nxt_rdata[`WWDT_UNF_BIT] = unf_ff; // R15
         nxt_rdata[`WWDT_ERR_BIT] = err_ff;
      end
   end

   // Read data register
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Outputs; the reset controller acts on the fault level
   assign rdata_o = rdata_ff;
   assign irq_o = irq_ff;
   assign fault_o = fault_ff;
   assign reset_all_o = reset_all_ff;
   assign reset_proc_o = reset_proc_ff;
   assign count_o = cnt_ff;
endmodule // wwdt_core

// ===== wwdt_slow_src.sv
`timescale 1ns/100ps
// Slow clock stand-in: one enable cycle every PERIOD fast cycles
module wwdt_slow_src #(parameter int PERIOD = 3) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Enable pulse towards the watchdog
   output logic slow_en_o
);
   logic [7:0] div_ff;
   // Free running, as the real oscillator never pauses
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_ff <= 8'h00;
         slow_en_o <= 1'b0;
      end else begin
         div_ff <= (div_ff == 8'(PERIOD - 1)) ? 8'h00 : div_ff + 8'h01;
         slow_en_o <= (div_ff == 8'h00);
      end
   end
endmodule // wwdt_slow_src

// ===== wwdt_core_monitor.sv
`timescale 1ns/100ps
// Port-level checks of the watchdog core
module wwdt_mon (
   // Clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // Register port
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   // Fault side and counter
   input wire irq_o,
   input wire fault_o,
   input wire reset_all_o,
   input wire reset_proc_o,
   input wire [11:0] count_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // Decoded strobes; a nonzero count rules out an underflow racing the read
   wire st_rd = rd_i && addr_i == 8'h08;
   wire cmd_wr = wr_i && addr_i == 8'h00;
   wire key_ok = wdata_i[31:24] == 8'hA5;
   AST_RD_CLR: assert property (st_rd && count_o != 12'h000 |=> !fault_o && !irq_o)
      else $error("fault kept after status read");
   AST_FLT_HOLD: assert property (fault_o && !st_rd |=> fault_o)
      else $error("fault dropped without status read");
   AST_IRQ_HOLD: assert property (irq_o && !st_rd && !wr_i |=> irq_o)
      else $error("interrupt dropped on its own");
   AST_ALL_PROC: assert property (reset_all_o |-> reset_proc_o && fault_o)
      else $error("full reset without processor reset");
   AST_PROC_FLT: assert property (reset_proc_o |-> fault_o)
      else $error("reset request without fault");
   AST_BAD_KEY: assert property (cmd_wr && !key_ok |=>
      count_o == $past(count_o) || count_o == $past(count_o) - 12'h001)
      else $error("wrong key changed the counter");
   AST_RESTART: assert property (cmd_wr && key_ok && wdata_i[0] |=>
      fault_o || count_o >= $past(count_o)) else $error("restart did not reload");
   AST_STEP: assert property (!wr_i ##1 count_o != $past(count_o) |->
      count_o == $past(count_o) - 12'h001) else $error("counter moved by more than one");
endmodule // wwdt_mon
bind wwdt_core wwdt_mon u_mon (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .irq_o(irq_o), .fault_o(fault_o),
   .reset_all_o(reset_all_o), .reset_proc_o(reset_proc_o), .count_o(count_o));

// ===== tb_wwdt_core.sv
`timescale 1ns/100ps
// Bench: register tasks drive the core, the slow source paces it
module tb_wwdt_core;
   logic clk_i, arst_n_i, wr_i, rd_i, slow_en_i, debug_state_i, idle_state_i;
   logic irq_o, fault_o, reset_all_o, reset_proc_o;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o, seed, c;
   logic [11:0] count_o, snap;
   int errors = 0, check_count = 0, i;
   wwdt_slow_src u_slow (.clk_i(clk_i), .arst_n_i(arst_n_i), .slow_en_o(slow_en_i));
   wwdt_core DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .slow_en_i(slow_en_i),
      .debug_state_i(debug_state_i), .idle_state_i(idle_state_i), .irq_o(irq_o),
      .fault_o(fault_o), .reset_all_o(reset_all_o), .reset_proc_o(reset_proc_o),
      .count_o(count_o));
   // 25 ns clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Next xorshift value
   function automatic [31:0] xs(input [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Configuration word: halt bits, window, flag bits, reload
   function automatic [31:0] cfg(input [1:0] h, input [11:0] w, input [3:0] f, input [11:0] v);
      return {2'h0, h, w, f, v};
   endfunction
   task automatic chk(input [31:0] got, input [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   // One strobe cycle; results are looked at just after the taking edge
   task automatic bus(input logic w, input [7:0] a, input [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= w;
      rd_i <= !w;
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      #1;
   endtask
   // Bounded wait for a fault and count pair
   task automatic wait_on(input [12:0] v);
      i = 0;
      while ({fault_o, count_o} !== v && i < 3000) begin
         @(posedge clk_i);
         #1 i++;
      end
   endtask
   task automatic end_of_test;
      if (errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      end_of_test;
   end
   // Main sequence
   initial begin
      {arst_n_i, wr_i, rd_i, debug_state_i, idle_state_i} = 5'h00;
      addr_i = 8'h00;
      wdata_i = 32'h0;
      seed = 32'h61;
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      bus(1'b0, 8'h04, 32'h0);
      chk(rdata_o, cfg(2'h3, 12'hFFF, 4'h2, 12'hFFF));
      // Debug, then idle, must freeze a running count
      for (int k = 1; k < 3; k++) begin
         repeat (400) @(posedge clk_i);
         {idle_state_i, debug_state_i} <= 2'(k);
         repeat (4) @(posedge clk_i);
         #1 snap = count_o;
         repeat (900) @(posedge clk_i);
         #1 chk({20'h0, count_o}, {20'h0, snap});
         @(posedge clk_i);
         {idle_state_i, debug_state_i} <= 2'h0;
      end
      // Random restart words carrying a wrong key
      repeat (8) begin
         seed = xs(seed);
         c = {seed[31:24] ^ ((seed[31:24] == 8'hA5) ? 8'hFF : 8'h00), seed[23:0] | 24'h1};
         bus(1'b1, 8'h00, c);
         chk({30'h0, count_o == 12'hFFF, fault_o}, 32'h0);
      end
      bus(1'b1, 8'h00, 32'hA5000001);
      chk({19'h0, fault_o, count_o}, 32'hFFF);
      c = cfg(2'h0, 12'h001, 4'h3, 12'h003);
      bus(1'b1, 8'h04, c);
      chk({20'h0, count_o}, 32'h3);
      bus(1'b1, 8'h04, 32'h0);
      bus(1'b0, 8'h04, 32'h0);
      chk(rdata_o, c);
      bus(1'b1, 8'h00, 32'hA5000001);
      chk({16'h0, fault_o, irq_o, reset_all_o, reset_proc_o, count_o}, 32'hF003);
      bus(1'b0, 8'h08, 32'h0);
      chk(rdata_o, 32'h2);
      chk({30'h0, fault_o, irq_o}, 32'h0);
      // In-window restart, then let it run out
      wait_on(13'h0001);
      bus(1'b1, 8'h00, 32'hA5000001);
      chk({19'h0, fault_o, count_o}, 32'h3);
      wait_on(13'h1000);
      chk({30'h0, irq_o, reset_proc_o}, 32'h3);
      bus(1'b0, 8'h08, 32'h0);
      chk(rdata_o, 32'h1);
      // Mid-run reset reopens the configuration
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      bus(1'b0, 8'h04, 32'h0);
      chk(rdata_o, cfg(2'h3, 12'hFFF, 4'h2, 12'hFFF));
      bus(1'b1, 8'h04, cfg(2'h0, 12'h00F, 4'hE, 12'h010));
      repeat (900) @(posedge clk_i);
      #1 chk({20'h0, count_o}, 32'h10);
      // Restart above the window while disabled; processor reset only
      bus(1'b1, 8'h00, 32'hA5000001);
      chk({16'h0, fault_o, irq_o, reset_all_o, reset_proc_o, count_o}, 32'h9010);
      // A second reset clears the fault without any status read
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk({16'h0, fault_o, irq_o, reset_all_o, reset_proc_o, count_o}, 32'hFFF);
      end_of_test;
   end
endmodule // tb_wwdt_core
